// ---- ffsm_consts.vh ----
`ifndef FFSM_CONSTS_VH
`define FFSM_CONSTS_VH

// Register byte addresses (printed offsets are all multiples of four)
`define FFSM_ADDR_CFG1        8'h00
`define FFSM_ADDR_CFG2        8'h04
`define FFSM_ADDR_STAT1       8'h08
`define FFSM_ADDR_SPEED       8'h20
`define FFSM_ADDR_LIMIT       8'h40
`define FFSM_ADDR_CHAR        8'h80
`define FFSM_ADDR_DRIVE       8'hc0
// Printed indices of the registers
`define FFSM_IDX_CFG1         8'h00
`define FFSM_IDX_CFG2         8'h01
`define FFSM_IDX_STAT1        8'h02
`define FFSM_IDX_SPEED        8'h08
`define FFSM_IDX_LIMIT        8'h10
`define FFSM_IDX_CHAR         8'h20

// Field positions
`define FFSM_CFG1_MON         0
`define FFSM_CFG1_INTEN       1
`define FFSM_CFG1_ANALOG      2
`define FFSM_CFG1_INV         3
`define FFSM_CFG1_FFEN        4
`define FFSM_CFG2_TACHEN      2
`define FFSM_STAT_ALARM       0
`define FFSM_STAT_FAULT       1
`define FFSM_CHAR_RANGE_HI    7
`define FFSM_CHAR_RANGE_LO    6
`define FFSM_CHAR_SPIN_HI     2
`define FFSM_CHAR_SPIN_LO     0

// Reset values
`define FFSM_CFG2_RST         8'h7f
`define FFSM_LIMIT_RST        8'hff
`define FFSM_CHAR_RST         8'h45
`define FFSM_DRIVE_RST        8'h00

// Timing
`define FFSM_CLK_HZ           25000000
`define FFSM_REF_HZ           11250
`define FFSM_REF_DIV          ((`FFSM_CLK_HZ) / (`FFSM_REF_HZ))
`define FFSM_TENTH_DIV        ((`FFSM_CLK_HZ) / 10)
`define FFSM_FAULT_LIMIT      3'h5
`define FFSM_COUNT_MAX        8'hff
`define FFSM_PWM_MAX          8'hef

`endif

// ---- ffsm_monitor.v ----
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - Range field picks divider N; resets 01
// - Failure pin active only when enabled
// - Slow or stalled fan is a fault
// - Failure pin asserts after five faults
// - Fault starts spin-up, or after read
// - Fault only when count exceeds limit
// - Five faults force full duty always
// - Fault sets status bit 1, interrupt
// - Status read clears the interrupt
// - Spin-up holds full duty, default 2s
// - Each fault before fifth restarts spin-up
// - Spin-up happens with failure pin disabled
// - Tach disable keeps fault detection alive
// - Alarm flag reflects variant condition
// - Alarm flag cleared only by status read
// - Alarm sets again only on new condition
// - Control waits for write of monitor bit
// - Reset defaults per variant
// - Measure two tach periods, saturate 255
// - Spin-up time code, reset 101
`include "ffsm_consts.vh"

module ffsm_monitor #(
    parameter [1:0] VARIANT    = 2'd0,        // 0, 1 or 2 selects power-on personality
    parameter       TENTH_DIV  = `FFSM_TENTH_DIV, // Cycles per 0.1 s
    parameter       REF_DIV    = `FFSM_REF_DIV    // Cycles per reference tick
) (
    input  wire        CLK_SYS,        // System clock 25 MHz
    input  wire        RESET,          // Asynchronous reset, active high
    input  wire        TACH_SENSE_IN,  // Fan tachometer, digital level
    input  wire        OVERTEMP_IN_N,  // Over-temperature output level, low active
    output reg         PWM_OUT,        // Fan drive output
    output reg         FAN_FAIL_N,     // Fan failure, active low
    output reg         INT_N,          // Interrupt, active low
    input  wire [7:0]  S_AXI_AWADDR,   // Write address
    input  wire        S_AXI_AWVALID,  // Write address valid
    output reg         S_AXI_AWREADY,  // Write address ready
    input  wire [31:0] S_AXI_WDATA,    // Write data
    input  wire [3:0]  S_AXI_WSTRB,    // Write strobes
    input  wire        S_AXI_WVALID,   // Write data valid
    output reg         S_AXI_WREADY,   // Write data ready
    output reg  [1:0]  S_AXI_BRESP,    // Write response
    output reg         S_AXI_BVALID,   // Write response valid
    input  wire        S_AXI_BREADY,   // Write response ready
    input  wire [7:0]  S_AXI_ARADDR,   // Read address
    input  wire        S_AXI_ARVALID,  // Read address valid
    output reg         S_AXI_ARREADY,  // Read address ready
    output reg  [31:0] S_AXI_RDATA,    // Read data
    output reg  [1:0]  S_AXI_RRESP,    // Read response
    output reg         S_AXI_RVALID,   // Read data valid
    input  wire        S_AXI_RREADY    // Read data ready
);

    // Measurement states
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_ARM   = 2'd1;
    localparam [1:0] ST_COUNT = 2'd2;

    // Variant-dependent reset of configuration 1
    localparam [7:0] CFG1_RST = (VARIANT == 2'd0) ? 8'h09 :
                                (VARIANT == 2'd1) ? 8'h01 : 8'h91;
    localparam [7:0] DRV_RST  = (VARIANT == 2'd0) ? 8'h50 : `FFSM_PWM_MAX;

    // Spin-up length in tenths of a second
    function [6:0] spin_tenths;
        input [2:0] code;
        begin
            case (code)
                3'd0:    spin_tenths = 7'd2;
                3'd1:    spin_tenths = 7'd4;
                3'd2:    spin_tenths = 7'd6;
                3'd3:    spin_tenths = 7'd8;
                3'd4:    spin_tenths = 7'd10;
                3'd5:    spin_tenths = 7'd20;
                3'd6:    spin_tenths = 7'd40;
                default: spin_tenths = 7'd80;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0]  cfg1_r;
    reg [7:0]  cfg2_r;
    reg [7:0]  limit_r;
    reg [7:0]  char_r;
    reg [7:0]  drive_r;
    reg        alarm_r;
    reg        fault_flag_r;
    reg        alarm_seen_r;
    reg        ctrl_on_r;
    reg [7:0]  speed_r;
    reg [2:0]  fault_cnt_r;
    reg        fault_pend_r;
    reg [6:0]  spin_left_r;
    reg [22:0] tenth_r;
    reg [11:0] ref_div_r;
    reg [7:0]  meas_r;
    reg [1:0]  edges_r;
    reg [1:0]  state_r;
    reg        tach_d_r;
    reg [7:0]  pwm_cnt_r;
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [7:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    wire [1:0] range_code = char_r[`FFSM_CHAR_RANGE_HI:`FFSM_CHAR_RANGE_LO];
    // Saturated fault count and spin-up activity
    wire       five       = (fault_cnt_r == `FFSM_FAULT_LIMIT);
    wire       spinning   = (spin_left_r != 7'd0);
    wire       full_duty  = five || spinning;
    wire       tach_rise  = TACH_SENSE_IN && !tach_d_r;
    wire       ref_tick   = (ref_div_r == 12'd0);
    wire       tenth_tick = (tenth_r == 23'd0);
    wire       rd_stat    = S_AXI_ARVALID && S_AXI_ARREADY &&
                            (S_AXI_ARADDR == `FFSM_ADDR_STAT1);
    // Two tach periods: done on the second rise after counting starts
    wire       meas_done  = (state_r == ST_COUNT) &&
                            ((tach_rise && edges_r == 2'd1) ||
                             (ref_tick && meas_r == `FFSM_COUNT_MAX));
    // Count over limit by at least one; slow or stalled alike
    wire       fault_now  = meas_done && (meas_r > limit_r);
    wire       spin_start = (VARIANT == 2'd1) ? (fault_pend_r && rd_stat) : fault_now;
    wire       alarm_cond = (VARIANT == 2'd1) ? (drive_r == `FFSM_PWM_MAX && !spinning)
                                              : !OVERTEMP_IN_N;
    // Write commits once address and data are both in hand
    wire       aw_take    = S_AXI_AWVALID && S_AXI_AWREADY;
    wire       w_take     = S_AXI_WVALID && S_AXI_WREADY;
    wire       wr_go      = (aw_hold_r || aw_take) && (w_hold_r || w_take);
    wire [7:0] wr_addr    = aw_hold_r ? aw_addr_r : S_AXI_AWADDR;
    wire [31:0] wr_data   = w_hold_r ? w_data_r : S_AXI_WDATA;
    wire [3:0] wr_strb    = w_hold_r ? w_strb_r : S_AXI_WSTRB;
    wire       wr_lane0   = wr_go && wr_strb[0];

    ////////////////////////////////////////////////////////////////////////
    // Reference clock divider and 0.1 s timebase; N scales reference tick
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ref_div_r <= 12'd0;
            tenth_r   <= 23'd0;
        end else begin
            // Reload on tick; larger N gives a shorter reference period
            ref_div_r <= ref_tick ? (REF_DIV[11:0] >> range_code) - 12'd1 : ref_div_r - 12'd1;
            tenth_r   <= tenth_tick ? TENTH_DIV[22:0] - 23'd1 : tenth_r - 23'd1;
        end
    end

    // Speed measurement, independent of tach enable for detection
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_r  <= ST_IDLE;
            meas_r   <= 8'h00;
            edges_r  <= 2'd0;
            speed_r  <= 8'h00;
            tach_d_r <= 1'b1;                                    // Idle high, no false edge
        end else begin
            tach_d_r <= TACH_SENSE_IN;
            case (state_r)
                ST_IDLE: begin
                    edges_r <= 2'd0;
                    meas_r  <= 8'h00;
                    state_r <= ST_ARM;
                end
                ST_ARM: begin
                    // First pulse skipped; count from second
                    if (tach_rise) begin
                        if (edges_r == 2'd1) begin
                            state_r <= ST_COUNT;
                            edges_r <= 2'd0;
                        end else begin
                            edges_r <= 2'd1;
                        end
                    end
                    // Restart on second pulse; stall timeout spans both waits
                    if (tach_rise && edges_r == 2'd1)
                        meas_r <= 8'h00;
                    else if (ref_tick && meas_r != `FFSM_COUNT_MAX)
                        meas_r <= meas_r + 8'h01;
                    if (ref_tick && meas_r == `FFSM_COUNT_MAX) begin
                        speed_r <= `FFSM_COUNT_MAX;                  // Stalled fan
                        state_r <= ST_IDLE;
                    end
                end
                ST_COUNT: begin
                    if (meas_done) begin
                        speed_r <= meas_r;
                        state_r <= ST_IDLE;
                    end else begin
                        if (tach_rise)
                            edges_r <= edges_r + 2'd1;
                        if (ref_tick)
                            meas_r <= meas_r + 8'h01;                // Saturates via meas_done
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Stall while arming also counts as a measurement result
    wire stall_done = (state_r == ST_ARM) && ref_tick && (meas_r == `FFSM_COUNT_MAX);
    wire fault_evt  = fault_now || (stall_done && (`FFSM_COUNT_MAX > limit_r));
    wire good_evt   = (meas_done && !fault_now) || (stall_done && !fault_evt);

    ////////////////////////////////////////////////////////////////////////
    // Fault counting, spin-up timer, status flags
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            fault_cnt_r  <= 3'd0;
            fault_pend_r <= 1'b0;
            spin_left_r  <= 7'd0;
            fault_flag_r <= 1'b0;
            alarm_r      <= 1'b0;
            alarm_seen_r <= 1'b0;
        end else begin
            // Count stops at five; only a clean measurement clears it
            if (fault_evt && !five)
                fault_cnt_r <= fault_cnt_r + 3'd1;
            else if (good_evt)
                fault_cnt_r <= 3'd0;
            // Deferred spin-up waits for status read
            if (fault_evt && VARIANT == 2'd1)
                fault_pend_r <= 1'b1;
            else if (rd_stat)
                fault_pend_r <= 1'b0;
            // Fresh spin-up on every fault, or on status read after a fault in variant 1; pin enabled or not
            if ((VARIANT == 2'd1) ? spin_start : fault_evt)
                spin_left_r <= spin_tenths(char_r[`FFSM_CHAR_SPIN_HI:`FFSM_CHAR_SPIN_LO]);
            else if (spinning && tenth_tick)
                spin_left_r <= spin_left_r - 7'd1;
            // Set wins over read-clear
            if (fault_evt)
                fault_flag_r <= 1'b1;
            else if (rd_stat)
                fault_flag_r <= 1'b0;
            // Rising condition only; read clears
            alarm_seen_r <= alarm_cond;
            if (alarm_cond && !alarm_seen_r)
                alarm_r <= 1'b1;
            else if (rd_stat)
                alarm_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive generator and pin outputs
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pwm_cnt_r  <= 8'h00;
            PWM_OUT    <= (VARIANT == 2'd0) ? 1'b0 : 1'b1;
            FAN_FAIL_N <= 1'b1;
            INT_N      <= 1'b1;
        end else begin
            // Free-running period counter, 240 steps
            pwm_cnt_r <= (pwm_cnt_r == `FFSM_PWM_MAX) ? 8'h00 : pwm_cnt_r + 8'h01;
            // Inverted when config bit set: high means drive on
            if (full_duty || !ctrl_on_r && VARIANT != 2'd0)
                PWM_OUT <= cfg1_r[`FFSM_CFG1_INV];
            else if (!ctrl_on_r)
                PWM_OUT <= 1'b0;
            else
                // On part of the period shows the polarity bit
                PWM_OUT <= (pwm_cnt_r < drive_r) ~^ cfg1_r[`FFSM_CFG1_INV];
            // Failure pin follows the saturated count, gated by its enable
            FAN_FAIL_N <= !(five && cfg1_r[`FFSM_CFG1_FFEN]);
            // Interrupt follows the fault flag; status read releases it
            INT_N      <= !(((fault_flag_r && !rd_stat) || fault_evt) &&
                            cfg1_r[`FFSM_CFG1_INTEN]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel and register writes
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'b00;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            cfg1_r        <= CFG1_RST;
            cfg2_r        <= `FFSM_CFG2_RST;
            limit_r       <= `FFSM_LIMIT_RST;
            char_r        <= `FFSM_CHAR_RST;
            drive_r       <= DRV_RST;
            ctrl_on_r     <= 1'b0;
        end else begin
            // Ready held high while idle so a waiting request is taken at once
            // Both readies low while a response is pending
            S_AXI_AWREADY <= !(aw_hold_r || aw_take || (S_AXI_BVALID && !S_AXI_BREADY));
            S_AXI_WREADY  <= !(w_hold_r || w_take || (S_AXI_BVALID && !S_AXI_BREADY));
            if (S_AXI_AWVALID && S_AXI_AWREADY && !wr_go) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY && !wr_go) begin
                w_hold_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= 2'b00;
                // Only the low byte lane carries register data
                if (wr_lane0) begin
                    case (wr_addr)
                        `FFSM_ADDR_CFG1: begin
                            cfg1_r <= wr_data[7:0];
                            if (wr_data[`FFSM_CFG1_MON])
                                ctrl_on_r <= 1'b1;
                        end
                        `FFSM_ADDR_CFG2:  cfg2_r  <= wr_data[7:0];
                        `FFSM_ADDR_LIMIT: limit_r <= wr_data[7:0];
                        `FFSM_ADDR_CHAR:  char_r  <= wr_data[7:0];
                        `FFSM_ADDR_DRIVE: drive_r <= wr_data[7:0];
                        `FFSM_ADDR_STAT1: S_AXI_BRESP <= 2'b10;
                        `FFSM_ADDR_SPEED: S_AXI_BRESP <= 2'b10;
                        default:          S_AXI_BRESP <= 2'b10;
                    endcase
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel; status read clears flags
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= 2'b00;
        end else begin
            // Address ready pulses once per request, never with data pending
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            // Read data latched at the address handshake, held until taken
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= 2'b00;
                case (S_AXI_ARADDR)
                    `FFSM_ADDR_CFG1:  S_AXI_RDATA <= {24'h000000, cfg1_r};
                    `FFSM_ADDR_CFG2:  S_AXI_RDATA <= {24'h000000, cfg2_r};
                    `FFSM_ADDR_STAT1: S_AXI_RDATA <= {30'h0, fault_flag_r, alarm_r};
                    `FFSM_ADDR_SPEED: S_AXI_RDATA <= {24'h000000, speed_r};
                    `FFSM_ADDR_LIMIT: S_AXI_RDATA <= {24'h000000, limit_r};
                    `FFSM_ADDR_CHAR:  S_AXI_RDATA <= {24'h000000, char_r};
                    `FFSM_ADDR_DRIVE: S_AXI_RDATA <= {24'h000000, drive_r};
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule

// ---- ffsm_checker.sv ----
`timescale 1ns/100ps
module ffsm_checker #(
    parameter [1:0] VARIANT = 2'd0  // Power-on personality
) (
    input wire        CLK_SYS,        // Clock
    input wire        RESET,          // Reset
    input wire        PWM_OUT,        // Fan drive
    input wire        FAN_FAIL_N,     // Fan failure
    input wire        INT_N,          // Interrupt
    input wire        S_AXI_AWVALID,  // AW valid
    input wire        S_AXI_AWREADY,  // AW ready
    input wire        S_AXI_WVALID,   // W valid
    input wire        S_AXI_WREADY,   // W ready
    input wire        S_AXI_BVALID,   // B valid
    input wire        S_AXI_BREADY,   // B ready
    input wire [7:0]  S_AXI_ARADDR,   // AR address
    input wire        S_AXI_ARVALID,  // AR valid
    input wire        S_AXI_ARREADY,  // AR ready
    input wire [31:0] S_AXI_RDATA,    // R data
    input wire [1:0]  S_AXI_RRESP,    // R response
    input wire        S_AXI_RVALID,   // R valid
    input wire        S_AXI_RREADY    // R ready
);
    ////////////////////////////////////////////////////////////////////////////////
    // Read handshakes and status reads
    wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire st_read = ar_take && (S_AXI_ARADDR == 8'h08);
    wire mapped  = S_AXI_ARADDR inside {8'h00, 8'h04, 8'h08, 8'h20, 8'h40, 8'h80, 8'hc0};
    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshakes
    chk_b_hold:
        assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response withdrawn");
    chk_b_soon:
        assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
                         |-> ##[1:2] S_AXI_BVALID)
        else $error("write response late");
    chk_r_next:
        assert property (ar_take |=> S_AXI_RVALID)
        else $error("read data late");
    chk_r_hold:
        assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data not held");
    chk_r_unmapped:
        assert property (ar_take && !mapped |=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt, spin-up and failure drive
    chk_int_holds:
        assert property (!INT_N && !st_read && !$past(st_read) && !$past(st_read, 2) |=> !INT_N)
        else $error("interrupt released without status read");
    chk_int_clears:
        assert property (st_read |-> ##[1:4] INT_N)
        else $error("status read left interrupt asserted");
    chk_fail_full:
        assert property (!FAN_FAIL_N && $past(FAN_FAIL_N) == 1'b0 |-> $stable(PWM_OUT))
        else $error("drive not steady after failure");
    chk_spin_steady:
        assert property (VARIANT == 2'd0 && $fell(INT_N) |-> ##2 $stable(PWM_OUT) [*6])
        else $error("drive not steady during spin-up");
endmodule

bind ffsm_monitor ffsm_checker #(.VARIANT(VARIANT)) u_chk (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .PWM_OUT(PWM_OUT), .FAN_FAIL_N(FAN_FAIL_N),
    .INT_N(INT_N), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY)
);

// ---- ffsm_fan_model.sv ----
`timescale 1ns/100ps
module ffsm_fan_model (
    input  wire        clk,          // System clock
    input  wire        drive,        // Drive level, not modelled
    input  wire [15:0] period,       // Tach period in cycles, zero stalls
    output reg         tach = 1'b1   // Tach output, pulled up when stalled
);
    reg [15:0] cnt_r = 16'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // Square-wave tach, held at the pull-up level while stalled
    always @(posedge clk) begin
        if (period == 16'h0 || cnt_r >= period - 16'h1) begin
            cnt_r <= 16'h0;
        end else begin
            cnt_r <= cnt_r + 16'h1;
        end
        tach <= (period == 16'h0) || (cnt_r < (period >> 1));
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, ot_n = 1'b1, tach, pwm, fail_n, int_n;
    logic [15:0] fan_per = 16'd128;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0, v, s;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    int          bad_count = 0, check_count = 0, k, hi;
    int          spin_tbl [8] = '{2, 4, 6, 8, 10, 20, 40, 80};
    // Clock and parts
    always #20 clk = ~clk;
    ffsm_monitor #(.VARIANT(2'd0), .TENTH_DIV(50), .REF_DIV(8)) DUT (
        .CLK_SYS(clk), .RESET(rst), .TACH_SENSE_IN(tach), .OVERTEMP_IN_N(ot_n), .PWM_OUT(pwm),
        .FAN_FAIL_N(fail_n), .INT_N(int_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    ffsm_fan_model FAN (.clk(clk), .drive(pwm), .period(fan_per), .tach(tach));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, checks and waits
    task summarize;
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task tmo;
        bad_count++;
        $display("BAD %0t wait expired", $time);
        summarize;
    endtask
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task cmpb(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wait_int;
        int n;
        for (n = 0; n < 20000 && int_n !== 1'b0; n++) @(posedge clk);
        if (int_n !== 1'b0) tmo;
    endtask
    function automatic logic fail_expect(input int faults);
        return faults < 5;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Register bus master
    task wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] rsp);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) tmo;
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] rsp);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) tmo;
        d = rdata[7:0];
        rsp = rresp;
        rready <= 1'b0;
    endtask
    task crd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic [1:0] q;
        rd(a, d, q);
        cmp(d, e);
        cmp({6'h0, q}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        k = $urandom(73);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cmpb(pwm, 1'b0);
        crd(8'h00, 8'h09);
        crd(8'h04, 8'h7f);
        crd(8'h40, 8'hff);
        crd(8'h80, 8'h45);
        crd(8'h08, 8'h00);
        rd(8'h0c, v, r);
        cmp({6'h0, r}, 8'h02);
        wr(8'h20, 8'h5a, r);
        cmp({6'h0, r}, 8'h02);
        // Random manual duty while control is not yet enabled
        for (k = 0; k < 3; k++) begin
            v = 8'($urandom % 240);
            wr(8'hc0, v, r);
            crd(8'hc0, v);
            cmpb(pwm, 1'b0);
        end
        // Alarm flag on the over-temperature level
        ot_n <= 1'b0;
        wt(6);
        ot_n <= 1'b1;
        wt(6);
        crd(8'h08, 8'h01);
        ot_n <= 1'b0;
        wt(6);
        crd(8'h08, 8'h01);
        crd(8'h08, 8'h00);
        ot_n <= 1'b1;
        wt(6);
        ot_n <= 1'b0;
        wt(6);
        crd(8'h08, 8'h01);
        ot_n <= 1'b1;
        // Running fan, digital tach, configuration written last
        fan_per <= 16'(64 * (1 + $urandom % 5));
        wr(8'hc0, 8'h50, r);
        wr(8'h80, 8'h41, r);
        wr(8'h00, 8'h0b, r);
        wt(2500);
        rd(8'h20, s, r);
        wt(2500);
        crd(8'h20, s);
        wr(8'h40, s, r);
        wt(2500);
        cmpb(int_n, 1'b1);
        hi = 0;
        repeat (240) begin
            @(posedge clk);
            hi += pwm;
        end
        cmp(8'(hi), 8'h50);
        wr(8'h40, s - 8'h01, r);
        wait_int();
        // Spin-up at full duty with the failure pin off
        for (k = 0; k < (spin_tbl[1] - 1) * 5; k++) begin
            wt(10);
            cmpb(pwm, 1'b1);
        end
        wr(8'h40, 8'hff, r);
        crd(8'h08, 8'h02);
        wt(4);
        cmpb(int_n, 1'b1);
        cmpb(fail_n, 1'b1);
        // Stalled fan, five consecutive faults
        wr(8'h00, 8'h1b, r);
        fan_per <= 16'h0;
        wt(3000);
        crd(8'h20, 8'hff);
        wr(8'h40, 8'h00, r);
        for (k = 1; k <= 5; k++) begin
            wait_int();
            wt(20);
            cmpb(pwm, 1'b1);
            cmpb(fail_n, fail_expect(k));
            crd(8'h08, 8'h02);
            if (k == 1) wr(8'h04, 8'h7b, r);
        end
        // Drive pinned to full duty after the fifth fault
        for (k = 0; k < 20; k++) begin
            wt(17);
            cmpb(pwm, 1'b1);
        end
        summarize;
    end
endmodule
